// File: cpu_regs_pkg.sv
package cpu_regs_pkg;

  // register byte offsets on the bus
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_STATUS     = 8'h00;
  localparam logic [7:0] OFS_CONTROL    = 8'h04;
  localparam logic [7:0] OFS_FAULT_ADDR = 8'h08;
  localparam logic [7:0] OFS_DIR_BASE   = 8'h0c;
  localparam logic [7:0] OFS_NEXT_INSTR = 8'h10;

  // status word field positions
  localparam int unsigned CF_BIT   = 0;
  localparam int unsigned PF_BIT   = 2;
  localparam int unsigned AF_BIT   = 4;
  localparam int unsigned ZF_BIT   = 6;
  localparam int unsigned SF_BIT   = 7;
  localparam int unsigned TF_BIT   = 8;
  localparam int unsigned IF_BIT   = 9;
  localparam int unsigned DF_BIT   = 10;
  localparam int unsigned OF_BIT   = 11;
  localparam int unsigned IO_PRIV_THRESHOLD_LO  = 12;
  localparam int unsigned IO_PRIV_THRESHOLD_HI  = 13;
  localparam int unsigned RF_BIT   = 16;
  localparam int unsigned VM_BIT   = 17;
  localparam int unsigned AC_BIT   = 18;

  // control word field positions
  localparam int unsigned PE_BIT = 0;
  localparam int unsigned MP_BIT = 1;
  localparam int unsigned EM_BIT = 2;
  localparam int unsigned TS_BIT = 3;
  localparam int unsigned WP_BIT = 16;
  localparam int unsigned AM_BIT = 18;
  localparam int unsigned CD_BIT = 30;
  localparam int unsigned PG_BIT = 31;

  // software-writable bits, fixed bits and reset values
  localparam logic [31:0] STATUS_SW_MASK  = 32'h0005_7fd5;
  localparam logic [31:0] STATUS_RESET    = 32'h0000_0000;
  localparam logic [31:0] CONTROL_SW_MASK = 32'hc005_000f;
  localparam logic [31:0] CONTROL_FIXED1  = 32'h0000_0010;
  localparam logic [31:0] CONTROL_RESET   = 32'h0000_0010;
  localparam logic [31:0] DIR_BASE_MASK   = 32'hffff_f000;
  localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;
  localparam logic [31:0] NEXT_INSTR_RESET = 32'h0000_0000;

  // register selector decoded from the bus address
  typedef enum logic [2:0] {
    SEL_STATUS,
    SEL_CONTROL,
    SEL_FAULT_ADDR,
    SEL_DIR_BASE,
    SEL_NEXT_INSTR,
    SEL_NONE
  } reg_sel_t;

endpackage

// File: alu_flags.sv
`timescale 1ns/1ps
// arithmetic flag generation for a 32-bit add or subtract
module alu_flags
  import cpu_regs_pkg::*;
(
  // operands
  input  wire logic [31:0] op_a,
  input  wire logic [31:0] op_b,
  input  wire logic        op_sub,
  // flags
  output logic             carry,
  output logic             parity,
  output logic             half_carry,
  output logic             zero,
  output logic             sign,
  output logic             overflow
);

  logic [32:0] sum;
  logic [31:0] res;

  // one 33-bit add or subtract gives carry or borrow out of bit 31
  always_comb begin
    if (op_sub) begin
      sum = {1'b0, op_a} - {1'b0, op_b};
    end else begin
      sum = {1'b0, op_a} + {1'b0, op_b};
    end
    res = sum[31:0];
  end

  assign carry      = sum[32];
  assign parity     = ~^res[7:0];
  assign half_carry = op_a[4] ^ op_b[4] ^ res[4];
  assign zero       = (res == ZERO_WORD);
  assign sign       = res[31];
  // carry into sign differs from out
  assign overflow   = (op_a[31] ^ op_b[31] ^ res[31]) ^ sum[32];

endmodule

// File: fault_gate.sv
`timescale 1ns/1ps
// registered fault decisions gated by status and control bits
module fault_gate (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // events from the pipeline
  input  wire logic       fp_instr,
  input  wire logic       wait_instr,
  input  wire logic       misalign_access,
  input  wire logic       ro_page_write,
  input  wire logic [1:0] current_priv_level,
  // gating bits
  input  wire logic       wait_monitor,
  input  wire logic       float_trap_all,
  input  wire logic       task_switched,
  input  wire logic       write_guard,
  input  wire logic       misalign_check,
  input  wire logic       misalign_gate,
  // fault pulses
  output logic            float_fault,
  output logic            coproc_absent_fault,
  output logic            align_fault,
  output logic            write_fault
);

  // one registered pulse per fault, one cycle after the event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      float_fault         <= 1'b0;
      coproc_absent_fault <= 1'b0;
      align_fault         <= 1'b0;
      write_fault         <= 1'b0;
    end else begin
      float_fault         <= fp_instr & float_trap_all;
      coproc_absent_fault <= task_switched & (fp_instr | (wait_instr & wait_monitor));
      align_fault         <= misalign_access & misalign_check & misalign_gate;
      write_fault         <= ro_page_write & (write_guard | (current_priv_level == 2'd3));
    end
  end

endmodule

// File: cpu_status_control_regs.sv
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps
// Overview of operation
// - next instruction offset advances per instruction unless flow change loads it.
// - carry flag shows carry or borrow out of the top bit.
// - parity flag set when low result byte holds even count of ones.
// - half carry flag shows carry or borrow across result bit 3.
// - zero flag marks zero result; sign flag copies result top bit.
// - overflow set when carry into sign differs from carry out.
// - step trap raises interrupt after next instruction; taking it clears bit.
// - maskable pin requests accepted only while interrupt allow bit set.
// - string ops increment indexes when direction clear, decrement when set.
// - io threshold bounds privilege for io and changing interrupt allow.
// - resume bit suppresses debug faults on the next instruction.
// - legacy mode faults privileged opcodes; set only by privileged return or task switch.
// - misalignment faults only when check and gate bits both set.
// - protection bit selects protected or legacy segment-times-sixteen addressing.
// - float trap bit makes every floating point instruction fault.
// - task switch sets flag; fp ops then fault, wait too with monitor.
// - write guard faults read-only writes at all levels; else levels 0-2 may.
// - fill inhibit stops new cache fills but hits still serve.
// - paging active only when paging and protection bits both set.
// - page fault with paging captures the full linear address.
// - directory base holds 20 aligned bits; low 12 bits reserved.
// - in protected mode control registers writable only at privilege 0.
module cpu_status_control_regs
  import cpu_regs_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // instruction flow
  input  wire logic              instr_retire,
  input  wire logic [3:0]        instr_len,
  input  wire logic              flow_load,
  input  wire logic [31:0]       flow_target,
  output logic [31:0]            next_instr_offset,
  // arithmetic results
  input  wire logic              alu_update,
  input  wire logic [31:0]       alu_a,
  input  wire logic [31:0]       alu_b,
  input  wire logic              alu_sub,
  // privilege and mode events
  input  wire logic [1:0]        current_priv_level,
  input  wire logic              task_switch,
  input  wire logic              iret_load,
  input  wire logic              vm_load_val,
  input  wire logic              step_taken,
  input  wire logic              debug_fault,
  input  wire logic              io_instr,
  input  wire logic              priv_opcode,
  // interrupt pin, asynchronous
  input  wire logic              maskable_irq_pin,
  // memory events
  input  wire logic              fp_instr,
  input  wire logic              wait_instr,
  input  wire logic              misalign_access,
  input  wire logic              ro_page_write,
  input  wire logic              page_fault,
  input  wire logic [31:0]       page_fault_addr,
  // address formation
  input  wire logic [15:0]       seg_value,
  input  wire logic [31:0]       seg_base,
  input  wire logic [31:0]       eff_offset,
  output logic [31:0]            linear_addr,
  // decisions and modes
  output logic                   step_trap_req,
  output logic                   irq_accept,
  output logic                   string_dec,
  output logic                   io_map_check,
  output logic                   gp_fault,
  output logic                   debug_fault_take,
  output logic                   legacy_mode,
  output logic                   float_fault,
  output logic                   coproc_absent_fault,
  output logic                   align_fault,
  output logic                   write_fault,
  output logic                   fill_allow,
  output logic                   paging_active,
  output logic                   real_mode
);

  logic [31:0] status_q;
  logic [31:0] control_q;
  logic [31:0] fault_addr_q;
  logic [31:0] dir_base_q;
  logic [31:0] next_q;
  logic [31:0] rdata_q;
  logic [31:0] lin_q;
  logic        irq_s1_q;
  logic        irq_s2_q;
  logic        step_q;
  logic        irq_acc_q;
  logic        iomap_q;
  logic        gp_q;
  logic        dbg_q;
  reg_sel_t    sel;
  logic        wr_en;
  logic        ctl_write_ok;
  logic        refused;
  logic        fl_cf;
  logic        fl_pf;
  logic        fl_af;
  logic        fl_zf;
  logic        fl_sf;
  logic        fl_of;
  logic        pe;
  logic        pg;
  logic [1:0]  io_priv_threshold;

  // address decode, used for both the read latch and the write
  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_STATUS:     decode = SEL_STATUS;
      OFS_CONTROL:    decode = SEL_CONTROL;
      OFS_FAULT_ADDR: decode = SEL_FAULT_ADDR;
      OFS_DIR_BASE:   decode = SEL_DIR_BASE;
      OFS_NEXT_INSTR: decode = SEL_NEXT_INSTR;
      default:        decode = SEL_NONE;
    endcase
  endfunction

  // privilege test shared by io and interrupt allow changes
  function automatic logic priv_within(input logic [1:0] level, input logic [1:0] limit);
    priv_within = (level <= limit);
  endfunction

  assign pe   = control_q[PE_BIT];
  assign pg   = control_q[PG_BIT];
  assign io_priv_threshold = status_q[IO_PRIV_THRESHOLD_HI:IO_PRIV_THRESHOLD_LO];
  assign sel  = decode(paddr);

  // control writes need privilege 0 when protected
  assign ctl_write_ok = !pe || (current_priv_level == 2'd0);
  // control, fault address and directory base are the guarded set; offset is read only
  assign refused = (sel == SEL_NONE)
                || (pwrite && (sel == SEL_NEXT_INSTR))
                || (pwrite && !ctl_write_ok
                    && (sel == SEL_CONTROL || sel == SEL_FAULT_ADDR || sel == SEL_DIR_BASE));

  // zero-wait slave; read data captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & refused;
  assign prdata  = rdata_q;
  assign wr_en   = psel & penable & pwrite & !refused;

  // read data latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= ZERO_WORD;
    end else if (psel && !penable) begin
      case (sel)
        SEL_STATUS:     rdata_q <= status_q;
        SEL_CONTROL:    rdata_q <= control_q;
        SEL_FAULT_ADDR: rdata_q <= fault_addr_q;
        SEL_DIR_BASE:   rdata_q <= dir_base_q;
        SEL_NEXT_INSTR: rdata_q <= next_q;
        default:        rdata_q <= ZERO_WORD;
      endcase
    end
  end

  // flag generator
  alu_flags u_flags (
    .op_a       (alu_a),
    .op_b       (alu_b),
    .op_sub     (alu_sub),
    .carry      (fl_cf),
    .parity     (fl_pf),
    .half_carry (fl_af),
    .zero       (fl_zf),
    .sign       (fl_sf),
    .overflow   (fl_of)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      next_q <= NEXT_INSTR_RESET;
    end else if (flow_load) begin
      next_q <= flow_target;
    end else if (instr_retire) begin
      next_q <= next_q + {28'h0000000, instr_len};
    end
  end

  // status word: software write first, hardware events override it except the retire clear of the resume bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= STATUS_RESET;
    end else begin
      if (wr_en && sel == SEL_STATUS) begin
        status_q <= (status_q & ~STATUS_SW_MASK) | (pwdata & STATUS_SW_MASK);
        // allow bit kept when privilege too low
        if (pe && !priv_within(current_priv_level, io_priv_threshold)) begin
          status_q[IF_BIT] <= status_q[IF_BIT];
        end
      end
      if (alu_update) begin
        status_q[CF_BIT] <= fl_cf;
        status_q[PF_BIT] <= fl_pf;
        status_q[AF_BIT] <= fl_af;
        status_q[ZF_BIT] <= fl_zf;
        status_q[SF_BIT] <= fl_sf;
        status_q[OF_BIT] <= fl_of;
      end
      if (instr_retire && !(wr_en && sel == SEL_STATUS)) begin
        status_q[RF_BIT] <= 1'b0;
      end
      // taking the step interrupt clears it
      if (step_taken) begin
        status_q[TF_BIT] <= 1'b0;
      end
      // legacy bit loaded only by task switch or privileged return
      if (task_switch || (iret_load && current_priv_level == 2'd0)) begin
        status_q[VM_BIT] <= vm_load_val;
      end
    end
  end

  // control word; task switch set wins over a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_q <= CONTROL_RESET;
    end else begin
      if (wr_en && sel == SEL_CONTROL) begin
        control_q <= (control_q & ~CONTROL_SW_MASK) | (pwdata & CONTROL_SW_MASK) | CONTROL_FIXED1;
      end
      if (task_switch) begin
        control_q[TS_BIT] <= 1'b1;
      end
    end
  end

  // fault address; a capture beats a software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_addr_q <= ZERO_WORD;
    end else if (page_fault && paging_active) begin
      fault_addr_q <= page_fault_addr;
    end else if (wr_en && sel == SEL_FAULT_ADDR) begin
      fault_addr_q <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_base_q <= ZERO_WORD;
    end else if (wr_en && sel == SEL_DIR_BASE) begin
      dir_base_q <= pwdata & DIR_BASE_MASK;
    end
  end

  // interrupt pin synchroniser; only the second stage is used
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_s1_q <= 1'b0;
      irq_s2_q <= 1'b0;
    end else begin
      irq_s1_q <= maskable_irq_pin;
      irq_s2_q <= irq_s1_q;
    end
  end

  // registered decisions, one cycle after their cause
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_q    <= 1'b0;
      irq_acc_q <= 1'b0;
      iomap_q   <= 1'b0;
      gp_q      <= 1'b0;
      dbg_q     <= 1'b0;
    end else begin
      step_q    <= instr_retire & status_q[TF_BIT];
      // maskable requests gated by allow bit
      irq_acc_q <= irq_s2_q & status_q[IF_BIT];
      // low privilege io goes to the map check
      iomap_q   <= io_instr & pe & !priv_within(current_priv_level, io_priv_threshold);
      // privileged opcodes fault in legacy mode
      gp_q      <= priv_opcode & legacy_mode;
      dbg_q     <= debug_fault & !status_q[RF_BIT];
    end
  end

  assign step_trap_req    = step_q;
  assign irq_accept       = irq_acc_q;
  assign io_map_check     = iomap_q;
  assign gp_fault         = gp_q;
  assign debug_fault_take = dbg_q;
  assign next_instr_offset = next_q;

  // real mode forms segment times sixteen plus offset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lin_q <= ZERO_WORD;
    end else if (pe) begin
      lin_q <= seg_base + eff_offset;
    end else begin
      lin_q <= {12'h000, seg_value, 4'h0} + eff_offset;
    end
  end
  assign linear_addr = lin_q;

  // mode levels straight from the stored bits
  // direction bit picks decrement
  assign string_dec    = status_q[DF_BIT];
  assign legacy_mode   = status_q[VM_BIT] & pe;
  assign fill_allow    = !control_q[CD_BIT];
  assign paging_active = pg & pe;
  assign real_mode     = !pe;

  // floating point, alignment and write-guard faults
  fault_gate u_faults (
    .pclk                (pclk),
    .presetn             (presetn),
    .fp_instr            (fp_instr),
    .wait_instr          (wait_instr),
    .misalign_access     (misalign_access),
    .ro_page_write       (ro_page_write),
    .current_priv_level                 (current_priv_level),
    .wait_monitor        (control_q[MP_BIT]),
    .float_trap_all      (control_q[EM_BIT]),
    .task_switched       (control_q[TS_BIT]),
    .write_guard         (control_q[WP_BIT]),
    .misalign_check      (status_q[AC_BIT]),
    .misalign_gate       (control_q[AM_BIT]),
    .float_fault         (float_fault),
    .coproc_absent_fault (coproc_absent_fault),
    .align_fault         (align_fault),
    .write_fault         (write_fault)
  );

  // checks on the stored state
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ip_advance_a: assert property (
    instr_retire && !flow_load |=> next_instr_offset == $past(next_instr_offset) + 32'($past(instr_len)))
    else $error("offset did not advance by length");
  ip_load_a: assert property (
    flow_load |=> next_instr_offset == $past(flow_target))
    else $error("flow target not loaded");
  carry_add_a: assert property (
    alu_update && !alu_sub |=> status_q[CF_BIT] == ((33'($past(alu_a)) + 33'($past(alu_b))) >> 32))
    else $error("carry flag wrong after add");
  zero_flag_a: assert property (
    alu_update && alu_a == alu_b && alu_sub |=> status_q[ZF_BIT] && !status_q[CF_BIT])
    else $error("equal subtract must give zero");
  step_trap_a: assert property (
    instr_retire && status_q[TF_BIT] |=> step_trap_req)
    else $error("single step trap missing");
  irq_gate_a: assert property (
    irq_accept |-> $past(status_q[IF_BIT]))
    else $error("interrupt accepted while masked");
  align_gate_a: assert property (
    misalign_access && !(status_q[AC_BIT] && control_q[AM_BIT]) |=> !align_fault)
    else $error("alignment fault while masked");
  ts_set_a: assert property (
    task_switch |=> control_q[TS_BIT])
    else $error("task switched flag not set");
  fault_capture_a: assert property (
    page_fault && !paging_active && !wr_en |=> $stable(fault_addr_q))
    else $error("fault address changed without paging");
  dir_low_a: assert property (
    dir_base_q[11:0] == 12'h000)
    else $error("directory base low bits set");
  ctl_guard_a: assert property (
    psel && penable && pwrite && sel == SEL_CONTROL && pe && current_priv_level != 2'd0 && !task_switch
      |=> $stable(control_q))
    else $error("control written from low privilege");

  step_cover_c:   cover property (instr_retire && status_q[TF_BIT] ##1 step_trap_req);
  capture_cover_c: cover property (page_fault && paging_active);
  refuse_cover_c: cover property (pslverr);

endmodule

// File: cpu_status_control_regs_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %s exp %h got %h", nm, e, g); end end
`define PULSE(s) begin @(posedge pclk); s <= 1'b1; @(posedge pclk); s <= 1'b0; #1; end
module cpu_status_control_regs_bench;
  import cpu_regs_pkg::*;
  // clock, reset and apb
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, a, b, v, rnd;
  // core side
  logic        instr_retire, flow_load, alu_update, alu_sub, task_switch, iret_load, vm_load_val, step_taken;
  logic        debug_fault, io_instr, priv_opcode, maskable_irq_pin, fp_instr, wait_instr, misalign_access;
  logic        ro_page_write, page_fault, step_trap_req, irq_accept, string_dec, io_map_check, gp_fault;
  logic        debug_fault_take, legacy_mode, float_fault, coproc_absent_fault, align_fault, write_fault;
  logic        fill_allow, paging_active, real_mode;
  logic [3:0]  instr_len;
  logic [1:0]  current_priv_level;
  logic [15:0] seg_value;
  logic [31:0] flow_target, next_instr_offset, alu_a, alu_b, page_fault_addr, seg_base, eff_offset, linear_addr;
  int          n_mismatch = 0;
  int          check_count = 0;
  logic [31:0] ca [4] = '{32'h0000_0000, 32'hffff_ffff, 32'h7fff_ffff, 32'h8000_0000};

  always #10 pclk = ~pclk;

  cpu_status_control_regs cpu_status_control_regs_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .instr_retire, .instr_len, .flow_load, .flow_target, .next_instr_offset,
    .alu_update, .alu_a, .alu_b, .alu_sub, .current_priv_level, .task_switch, .iret_load, .vm_load_val,
    .step_taken, .debug_fault, .io_instr, .priv_opcode, .maskable_irq_pin, .fp_instr, .wait_instr,
    .misalign_access, .ro_page_write, .page_fault, .page_fault_addr, .seg_value, .seg_base,
    .eff_offset, .linear_addr, .step_trap_req, .irq_accept, .string_dec, .io_map_check, .gp_fault,
    .debug_fault_take, .legacy_mode, .float_fault, .coproc_absent_fault, .align_fault, .write_fault,
    .fill_allow, .paging_active, .real_mode
  );

  // shift register keeps the random stream repeatable
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // expected arithmetic flags of a 32-bit add or subtract
  function automatic logic [31:0] flags_of(logic [31:0] x, logic [31:0] y, logic s);
    logic [32:0] r;
    logic [4:0]  h;
    logic [31:0] f;
    r = s ? {1'b0, x} - {1'b0, y} : {1'b0, x} + {1'b0, y};
    h = s ? {1'b0, x[3:0]} - {1'b0, y[3:0]} : {1'b0, x[3:0]} + {1'b0, y[3:0]};
    f = ZERO_WORD;
    f[CF_BIT] = r[32];
    f[PF_BIT] = ~^r[7:0];
    f[AF_BIT] = h[4];
    f[ZF_BIT] = (r[31:0] == ZERO_WORD);
    f[SF_BIT] = r[31];
    f[OF_BIT] = (x[31] ^ r[31]) & ~(x[31] ^ y[31] ^ s);
    return f;
  endfunction

  // one apb transfer; read data and error taken at the pready edge
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) n_mismatch++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge pclk);
    n_mismatch++;
    wrap_up;
  end

  initial begin
    {presetn, psel, penable, pwrite, instr_retire, flow_load, alu_update, alu_sub, task_switch} = '0;
    {iret_load, vm_load_val, step_taken, debug_fault, io_instr, priv_opcode, maskable_irq_pin} = '0;
    {fp_instr, wait_instr, misalign_access, ro_page_write, page_fault, instr_len, current_priv_level} = '0;
    {paddr, pwdata, flow_target, alu_a, alu_b, page_fault_addr, seg_value, seg_base, eff_offset} = '0;
    rnd = 32'h840bcd63;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_CONTROL, ZERO_WORD);
    `CHK("ctl_reset", CONTROL_RESET, rd)
    // flag corners first, then random operands
    for (int i = 0; i < 24; i++) begin
      a = (i < 4) ? ca[i] : rnd;
      rnd = lfsr(rnd);
      b = (i < 4) ? {31'h0, i != 0} : rnd;
      rnd = lfsr(rnd);
      @(posedge pclk);
      {alu_a, alu_b, alu_sub, alu_update} <= {a, b, (i < 4) ? i[1] : rnd[5], 1'b1};
      {seg_value, seg_base, eff_offset} <= {a[15:0], rnd, b};
      @(posedge pclk);
      alu_update <= 1'b0;
      apb(1'b0, OFS_STATUS, ZERO_WORD);
      `CHK("flags", flags_of(a, b, alu_sub), rd & 32'h0000_08d5)
      `CHK("real_addr", {12'h0, a[15:0], 4'h0} + b, linear_addr)
    end
    // flow load wins over a retire on the same edge
    @(posedge pclk);
    {instr_len, instr_retire} <= {4'h3, 1'b1};
    @(posedge pclk);
    {flow_target, flow_load} <= {32'h0000_0100, 1'b1};
    @(posedge pclk);
    {instr_len, flow_load} <= {4'hf, 1'b0};
    @(posedge pclk);
    instr_retire <= 1'b0;
    apb(1'b1, OFS_NEXT_INSTR, ZERO_WORD);
    `CHK("next_ro", 1'b1, err)
    apb(1'b0, OFS_NEXT_INSTR, ZERO_WORD);
    `CHK("next_instr", 32'h0000_010f, rd)
    apb(1'b1, OFS_CONTROL, 32'hffff_ffff);
    apb(1'b0, OFS_CONTROL, ZERO_WORD);
    `CHK("ctl_all", 32'hc005_001f, rd)
    `CHK("modes", 3'b010, {real_mode, paging_active, fill_allow})
    @(posedge pclk);
    current_priv_level <= 2'd3;
    apb(1'b1, OFS_CONTROL, ZERO_WORD);
    `CHK("ctl_refused", 1'b1, err)
    `PULSE(ro_page_write)
    `CHK("wp_fault", 1'b1, write_fault)
    `PULSE(fp_instr)
    `CHK("fp_faults", 2'b11, {float_fault, coproc_absent_fault})
    `PULSE(wait_instr)
    `CHK("wait_fault", 1'b1, coproc_absent_fault)
    // interrupt allow write ignored above the io threshold
    apb(1'b1, OFS_STATUS, 32'h0004_0600);
    apb(1'b0, OFS_STATUS, ZERO_WORD);
    `CHK("st_low_priv", 32'h0004_0400, rd)
    `CHK("str_dec", 1'b1, string_dec)
    `PULSE(misalign_access)
    `CHK("align_on", 1'b1, align_fault)
    @(posedge pclk);
    {maskable_irq_pin, current_priv_level} <= {1'b1, 2'd0};
    repeat (3) @(posedge pclk);
    #1;
    `CHK("irq_masked", 1'b0, irq_accept)
    apb(1'b1, OFS_STATUS, 32'h0004_0600);
    @(posedge pclk);
    #1;
    `CHK("irq_taken", 1'b1, irq_accept)
    apb(1'b1, OFS_CONTROL, 32'h8000_0000);
    `CHK("pg_no_pe", 2'b10, {real_mode, paging_active})
    `PULSE(misalign_access)
    `CHK("align_gated", 1'b0, align_fault)
    `PULSE(ro_page_write)
    `CHK("wp_off_l0", 1'b0, write_fault)
    `PULSE(task_switch)
    apb(1'b0, OFS_CONTROL, ZERO_WORD);
    `CHK("ts_set", 1'b1, rd[TS_BIT])
    apb(1'b1, OFS_CONTROL, 32'h8000_0001);
    v = rnd;
    page_fault_addr <= v;
    `PULSE(page_fault)
    apb(1'b0, OFS_FAULT_ADDR, ZERO_WORD);
    `CHK("fault_addr", v, rd)
    apb(1'b1, OFS_DIR_BASE, ~v);
    apb(1'b0, OFS_DIR_BASE, ZERO_WORD);
    `CHK("dir_base", ~v & DIR_BASE_MASK, rd)
    apb(1'b0, 8'h14, ZERO_WORD);
    `CHK("unmapped", 33'h1_0000_0000, {err, rd})
    apb(1'b1, OFS_STATUS, 32'h0000_0100);
    `PULSE(step_taken)
    apb(1'b0, OFS_STATUS, ZERO_WORD);
    `CHK("tf_clear", 1'b0, rd[TF_BIT])
    // equal subtract must land on zero with no borrow
    @(posedge pclk);
    {alu_a, alu_b, alu_sub, alu_update} <= {v, v, 1'b1, 1'b1};
    @(posedge pclk);
    alu_update <= 1'b0;
    apb(1'b0, OFS_STATUS, ZERO_WORD);
    `CHK("eq_flags", flags_of(v, v, 1'b1), rd & 32'h0000_08d5)
    // step trap fires after the next completed instruction
    apb(1'b1, OFS_STATUS, 32'h0000_0100);
    `PULSE(instr_retire)
    `CHK("step_req", 1'b1, step_trap_req)
    // resume bit masks one debug fault, retire clears it
    apb(1'b1, OFS_STATUS, 32'h0001_0000);
    `PULSE(debug_fault)
    `CHK("dbg_masked", 1'b0, debug_fault_take)
    `PULSE(instr_retire)
    `PULSE(debug_fault)
    `CHK("dbg_taken", 1'b1, debug_fault_take)
    // low privilege io in protected mode goes to the map check
    @(posedge pclk);
    current_priv_level <= 2'd3;
    `PULSE(io_instr)
    `CHK("io_map", 1'b1, io_map_check)
    // task switch loads legacy mode, privileged opcodes then fault
    vm_load_val <= 1'b1;
    `PULSE(task_switch)
    `PULSE(priv_opcode)
    `CHK("legacy_gp", 2'b11, {legacy_mode, gp_fault})
    wrap_up;
  end
endmodule
